// ==== aisd_top.sv ====
// Digital side of the four-channel input block: range codes, scaling,
// diagnostic record with timestamp and the record access port.
// Assumes converter samples and monitor flags arrive on MCLK_IN; only the
// auxiliary supply sense is a raw pin and is synchronised here.
`timescale 1ns/1ps
module aisd_top (
	input  wire logic                      MCLK_IN,
	input  wire logic                      RESETN_IN,
	input  wire logic [3:0][15:0]          AI_RAW_IN,
	input  wire logic                      AI_VALID_IN,
	input  wire logic                      MOD_FAIL_IN,
	input  wire logic                      INT_ERR_IN,
	input  wire logic                      AUX_OK_IN,
	input  wire aisd_pkg::aisd_req_t       REC_REQ_IN,
	output logic [7:0]                     REC_RDATA_OUT,
	output logic                           REC_ACK_OUT,
	output logic                           REC_ERR_OUT,
	output logic [3:0][15:0]               AI_VALUE_OUT,
	output logic [3:0]                     CH_LED_OUT,
	output logic                           MOD_LED_OUT
);
	localparam int NCH = aisd_pkg::NUM_CH;

	// Microsecond divider and ticker
	logic [7:0]  div_ff;         // Cycle count inside one microsecond
	logic        tick_ff;        // One-cycle microsecond enable
	logic [31:0] ticker_ff;      // Free-running microsecond count
	// Parameters and diagnostic state
	logic [7:0]  code_ff [NCH];  // Range code per channel
	logic [7:0]  fault_ff [NCH]; // Per-channel fault byte
	logic [7:0]  summary_ff;     // Module fault summary
	logic [31:0] stamp_ff;       // Timestamp of last diagnostic event
	// Supply sense synchroniser
	logic        aux_meta_ff;
	logic        aux_ok_ff;

	wire logic div_last = (div_ff == 8'(aisd_pkg::US_CYCLES - 1));

	// divider restarts from zero at reset
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			div_ff  <= 8'h00;
			tick_ff <= 1'b0;
		end else begin
			div_ff  <= div_last ? 8'h00 : div_ff + 8'h01;
			tick_ff <= div_last;
		end
	end

	// ticker wraps naturally at 32 bits
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			ticker_ff <= 32'h0000_0000;
		end else if (tick_ff) begin
			ticker_ff <= ticker_ff + 32'h0000_0001;
		end
	end

	// Two flops before anything reads the supply sense pin
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			aux_meta_ff <= 1'b1;
			aux_ok_ff   <= 1'b1;
		end else begin
			aux_meta_ff <= AUX_OK_IN;
			aux_ok_ff   <= aux_meta_ff;
		end
	end

	// Record address decode
	wire logic       is_full  = (REC_REQ_IN.num == aisd_pkg::REC_DIAG_FULL);
	wire logic       is_head  = (REC_REQ_IN.num == aisd_pkg::REC_DIAG_HEAD);
	wire logic       is_param = ((REC_REQ_IN.num & aisd_pkg::REC_PARAM_MASK)
	                             == aisd_pkg::REC_PARAM_BASE);
	wire logic [1:0] par_ch   = REC_REQ_IN.num[1:0];
	wire logic       idx_zero = (REC_REQ_IN.idx == 5'h00);
	// full record and short head record
	wire logic rd_ok = (is_full && (REC_REQ_IN.idx < 5'(aisd_pkg::DIAG_LEN)))
	                || (is_head && (REC_REQ_IN.idx < 5'(aisd_pkg::HEAD_LEN)))
	                || (is_param && idx_zero);
	wire logic wr_ok = is_param && idx_zero;
	wire logic par_wr = REC_REQ_IN.wr && wr_ok;

	// Scaling per channel and next fault bytes
	aisd_pkg::aisd_scaled_t scaled [NCH];
	logic [7:0] nxt_fault [NCH];
	logic [NCH-1:0] ch_bad;      // Any fault bit in the next channel byte
	logic [NCH-1:0] ch_param;    // Parameter error in the next channel byte
	logic [NCH-1:0] ch_range;    // Range violation in the next channel byte

	genvar g;
	generate
		for (g = 0; g < NCH; g++) begin : g_ch
			aisd_scale u_scale (
				.raw_in  (AI_RAW_IN[g]),
				.code_in (code_ff[g]),
				.res_out (scaled[g])
			);

			// a deactivated channel drops range faults it still held, else
			// a stale overflow would keep its LED lit with no measurement running
			wire logic over_bit  = scaled[g].off ? 1'b0 :
			                       AI_VALID_IN ? scaled[g].over : fault_ff[g][aisd_pkg::CHF_OVER];
			wire logic under_bit = scaled[g].off ? 1'b0 :
			                       AI_VALID_IN ? scaled[g].under : fault_ff[g][aisd_pkg::CHF_UNDER];
			// parameter bit follows the code at once; range bits on samples
			assign nxt_fault[g] = {over_bit, under_bit, 5'b00000, scaled[g].bad_code};
			assign ch_bad[g]   = |nxt_fault[g];
			assign ch_param[g] = nxt_fault[g][aisd_pkg::CHF_PARAM];
			assign ch_range[g] = nxt_fault[g][aisd_pkg::CHF_OVER]
			                   | nxt_fault[g][aisd_pkg::CHF_UNDER];

			// code defaults to format A after reset
			always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					code_ff[g] <= aisd_pkg::CODE_RESET;
				end else if (par_wr && (par_ch == 2'(g))) begin
					code_ff[g] <= REC_REQ_IN.wdata;
				end
			end

			// deactivated channel holds zero value and no faults
			always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
				if (!RESETN_IN) begin
					fault_ff[g]     <= 8'h00;
					AI_VALUE_OUT[g] <= 16'h0000;
					CH_LED_OUT[g]   <= 1'b0;
				end else begin
					fault_ff[g]   <= nxt_fault[g];
					// channel LED follows the fault byte
					CH_LED_OUT[g] <= ch_bad[g];
					if (AI_VALID_IN || scaled[g].off) begin
						AI_VALUE_OUT[g] <= scaled[g].value;
					end
				end
			end
		end
	endgenerate

	// summary byte, bits 6-5 held at zero
	wire logic [7:0] nxt_summary;
	assign nxt_summary[aisd_pkg::SUM_MOD_FAIL] = MOD_FAIL_IN;
	assign nxt_summary[aisd_pkg::SUM_INTERNAL] = INT_ERR_IN;
	assign nxt_summary[aisd_pkg::SUM_EXTERNAL] = |ch_range;
	// any channel fault raises the channel error bit
	assign nxt_summary[aisd_pkg::SUM_CHANNEL]  = |ch_bad;
	assign nxt_summary[aisd_pkg::SUM_AUX_MISS] = !aux_ok_ff;
	assign nxt_summary[6:5]                    = 2'b00;
	assign nxt_summary[aisd_pkg::SUM_PARAM]    = |ch_param;

	// an event is any fault bit newly appearing
	logic [NCH*8+7:0] cur_vec;
	logic [NCH*8+7:0] nxt_vec;
	always_comb begin
		cur_vec = {{(NCH*8){1'b0}}, summary_ff};
		nxt_vec = {{(NCH*8){1'b0}}, nxt_summary};
		for (int i = 0; i < NCH; i++) begin
			cur_vec[8*i+8 +: 8] = fault_ff[i];
			nxt_vec[8*i+8 +: 8] = nxt_fault[i];
		end
	end
	wire logic diag_evt = |(nxt_vec & ~cur_vec);

	// Summary, timestamp and module LED
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			summary_ff  <= 8'h00;
			stamp_ff    <= 32'h0000_0000;
			MOD_LED_OUT <= 1'b0;
		end else begin
			summary_ff  <= nxt_summary;
			MOD_LED_OUT <= |nxt_summary;
			// capture the ticker at the event
			if (diag_evt) begin
				stamp_ff <= ticker_ff;
			end
		end
	end

	// group byte, bit n for channel n, upper nibble zero
	wire logic [7:0] group_byte = {4'h0, fault_ff[3] != 8'h00, fault_ff[2] != 8'h00,
	                                     fault_ff[1] != 8'h00, fault_ff[0] != 8'h00};

	// Record image, byte 0 in the low lane
	// class, kind, bits per channel, channel count
	// reserved byte 2, aux byte 3 and channels 4-7 read zero
	wire logic [8*aisd_pkg::DIAG_LEN-1:0] diag_rec = {
		stamp_ff,
		32'h0000_0000,
		fault_ff[3], fault_ff[2], fault_ff[1], fault_ff[0],
		group_byte,
		aisd_pkg::CH_COUNT,
		aisd_pkg::BITS_PER_CH,
		aisd_pkg::KIND_AI,
		8'h00,
		8'h00,
		aisd_pkg::CLASS_INFO,
		summary_ff
	};
	wire logic [7:0] rd_byte = is_param ? code_ff[par_ch]
	                                    : diag_rec[8*REC_REQ_IN.idx +: 8];

	// status leaves only through polled reads and the LEDs; no interrupt exists
	always_ff @(posedge MCLK_IN or negedge RESETN_IN) begin
		if (!RESETN_IN) begin
			REC_RDATA_OUT <= 8'h00;
			REC_ACK_OUT   <= 1'b0;
			REC_ERR_OUT   <= 1'b0;
		end else begin
			REC_ACK_OUT   <= REC_REQ_IN.rd | REC_REQ_IN.wr;
			REC_ERR_OUT   <= (REC_REQ_IN.rd & !rd_ok) | (REC_REQ_IN.wr & !wr_ok);
			// Refused reads return zero so no stale byte looks valid
			REC_RDATA_OUT <= (REC_REQ_IN.rd && rd_ok) ? rd_byte : 8'h00;
		end
	end

	// Checks
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RESETN_IN);

	tick_period_a: assert property (tick_ff |-> ##200 tick_ff)
		else $error("Microsecond tick spacing wrong");

	ticker_step_a: assert property (tick_ff |=> ticker_ff == $past(ticker_ff) + 32'h1)
		else $error("Ticker did not step by one");

	off_value_a: assert property (
		code_ff[0] == aisd_pkg::CODE_OFF |=> AI_VALUE_OUT[0] == 16'h0000 && !CH_LED_OUT[0])
		else $error("Deactivated channel shows a value or fault");

	fmt_a_lim_a: assert property (
		AI_VALID_IN && code_ff[1] == aisd_pkg::CODE_FMT_A && !scaled[1].over
		|=> $signed(AI_VALUE_OUT[1]) <= 16'sd32511)
		else $error("Format A value beyond overrange");

	fmt_b_ovr_a: assert property (
		AI_VALID_IN && code_ff[2] == aisd_pkg::CODE_FMT_B && AI_RAW_IN[2] == 16'h4000
		|=> AI_VALUE_OUT[2] == 16'h4000 && fault_ff[2] == 8'h00)
		else $error("Format B full scale wrong");

	led_follow_a: assert property (
		fault_ff[3] != 8'h00 |-> ##[0:1] CH_LED_OUT[3])
		else $error("Channel LED not lit on fault");

	head_len_a: assert property (
		REC_REQ_IN.rd && is_head && REC_REQ_IN.idx > 5'h03
		|=> REC_ERR_OUT && REC_ACK_OUT && REC_RDATA_OUT == 8'h00)
		else $error("Short record served past byte three");

	group_sum_a: assert property (
		group_byte != 8'h00 |-> summary_ff[aisd_pkg::SUM_CHANNEL])
		else $error("Channel error bit missing");

	rsvd_zero_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx >= aisd_pkg::IDX_FIRST_RSVD
		&& REC_REQ_IN.idx < aisd_pkg::IDX_STAMP |=> REC_RDATA_OUT == 8'h00)
		else $error("Reserved record byte not zero");

	stamp_take_a: assert property (diag_evt |=> stamp_ff == $past(ticker_ff))
		else $error("Timestamp not captured at event");

	// Fixed record bytes and the group byte, answered one cycle after the read strobe
	sum_rsvd_a: assert property (
		REC_REQ_IN.rd && is_full && idx_zero |=> REC_RDATA_OUT[6:5] == 2'b00)
		else $error("Summary reserved bits set");

	class_byte_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx == 5'h01 |=> REC_RDATA_OUT == aisd_pkg::CLASS_INFO)
		else $error("Class byte wrong");

	kind_byte_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx == 5'h04 |=> REC_RDATA_OUT == aisd_pkg::KIND_AI)
		else $error("Channel kind byte wrong");

	bit_count_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx == 5'h05 |=> REC_RDATA_OUT == aisd_pkg::BITS_PER_CH)
		else $error("Bits per channel byte wrong");

	ch_count_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx == 5'h06 |=> REC_RDATA_OUT == aisd_pkg::CH_COUNT)
		else $error("Channel count byte wrong");

	group_read_a: assert property (
		REC_REQ_IN.rd && is_full && REC_REQ_IN.idx == 5'h07 |=> REC_RDATA_OUT == {4'h0, $past(CH_LED_OUT)})
		else $error("Group byte disagrees with channel LEDs");

	param_bit_a: assert property (
		code_ff[1] != aisd_pkg::CODE_FMT_A && code_ff[1] != aisd_pkg::CODE_FMT_B
		&& code_ff[1] != aisd_pkg::CODE_OFF |=> fault_ff[1][aisd_pkg::CHF_PARAM])
		else $error("Bad range code not flagged");

	aux_sum_a: assert property (!aux_ok_ff |=> summary_ff[aisd_pkg::SUM_AUX_MISS])
		else $error("Missing supply not in summary");

	ack_next_a: assert property ((REC_REQ_IN.rd || REC_REQ_IN.wr) |=> REC_ACK_OUT)
		else $error("Record request not acknowledged");

	idle_data_a: assert property (!REC_REQ_IN.rd |=> REC_RDATA_OUT == 8'h00)
		else $error("Read data shown without a read");

endmodule : aisd_top

// ==== aisd_pkg.sv ====
// Shared constants and carriers for the four-channel 0-10 V input block.
// Assumes one 200 MHz clock; the record port is driven by on-chip logic.
package aisd_pkg;

	// Timing: one ticker step per microsecond
	localparam int CLK_PERIOD_NS = 5;
	localparam int US_PERIOD_NS  = 1000;
	localparam int US_CYCLES     = (US_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Channel and record geometry
	localparam int NUM_CH   = 4;
	localparam int DIAG_LEN = 20;     // Bytes in the full diagnostic record
	localparam int HEAD_LEN = 4;      // Bytes served under the short record

	// Record set numbers
	localparam logic [7:0] REC_DIAG_HEAD  = 8'h00;
	localparam logic [7:0] REC_DIAG_FULL  = 8'h01;
	localparam logic [7:0] REC_PARAM_BASE = 8'h80;  // 80h..83h, one per channel
	localparam logic [7:0] REC_PARAM_MASK = 8'hfc;

	// Range codes
	localparam logic [7:0] CODE_FMT_A = 8'h10;      // 27648 full scale
	localparam logic [7:0] CODE_FMT_B = 8'h20;      // 16384 full scale
	localparam logic [7:0] CODE_OFF   = 8'hff;
	localparam logic [7:0] CODE_RESET = CODE_FMT_A;

	// Scaling limits, signed 16-bit
	localparam logic signed [21:0] LIM_A_HI = 22'sd32511;
	localparam logic signed [21:0] LIM_A_LO = -22'sd4864;
	localparam logic signed [21:0] LIM_B_HI = 22'sd20480;
	localparam logic signed [21:0] LIM_B_LO = -22'sd3277;
	localparam logic [15:0] SAT_HI = 16'h7fff;      // Shown on overflow
	localparam logic [15:0] SAT_LO = 16'h8000;      // Shown on underflow
	localparam logic [4:0]  FMT_A_MUL = 5'h1b;      // 27648/16384 = 27/16
	localparam int          FMT_A_SHIFT = 4;

	// Fixed record bytes
	localparam logic [7:0] CLASS_INFO  = 8'h15;     // Class 0101b, channel info
	localparam logic [7:0] KIND_AI     = 8'h71;
	localparam logic [7:0] BITS_PER_CH = 8'h08;
	localparam logic [7:0] CH_COUNT    = 8'h04;

	// Summary byte bit positions
	localparam int SUM_MOD_FAIL = 0;
	localparam int SUM_INTERNAL = 1;
	localparam int SUM_EXTERNAL = 2;
	localparam int SUM_CHANNEL  = 3;
	localparam int SUM_AUX_MISS = 4;
	localparam int SUM_PARAM    = 7;

	// Channel fault bit positions
	localparam int CHF_PARAM = 0;
	localparam int CHF_UNDER = 6;
	localparam int CHF_OVER  = 7;

	// Byte positions inside the record
	localparam logic [4:0] IDX_FIRST_RSVD = 5'h0c;
	localparam logic [4:0] IDX_STAMP      = 5'h10;

	// Record request from the coupler side
	typedef struct packed {
		logic       rd;     // One-cycle read strobe
		logic       wr;     // One-cycle write strobe
		logic [7:0] num;    // Record set number
		logic [4:0] idx;    // Byte index inside the record
		logic [7:0] wdata;  // Write byte
	} aisd_req_t;

	// Scaled result of one channel
	typedef struct packed {
		logic [15:0] value;
		logic        over;
		logic        under;
		logic        bad_code;
		logic        off;
	} aisd_scaled_t;

endpackage : aisd_pkg

// ==== aisd_scale.sv ====
// Scaler for one channel: raw converter code to the selected format.
// Raw input is signed with 10 V = 16384; combinational, caller registers.
`timescale 1ns/1ps
module aisd_scale (
	input  wire logic [15:0]          raw_in,
	input  wire logic [7:0]           code_in,
	output aisd_pkg::aisd_scaled_t    res_out
);
	// Raw value widened for the 27/16 product
	wire logic signed [21:0] raw_w = {{6{raw_in[15]}}, raw_in};
	// Product fits 21 bits plus sign for any 16-bit raw
	wire logic signed [21:0] prod_a = raw_w * $signed({1'b0, aisd_pkg::FMT_A_MUL});
	wire logic signed [21:0] fmt_a  = prod_a >>> aisd_pkg::FMT_A_SHIFT;
	wire logic signed [21:0] fmt_b  = raw_w;

	// Code decode
	wire logic is_a   = (code_in == aisd_pkg::CODE_FMT_A);
	wire logic is_b   = (code_in == aisd_pkg::CODE_FMT_B);
	wire logic is_off = (code_in == aisd_pkg::CODE_OFF);

	wire logic ovr_a = fmt_a > aisd_pkg::LIM_A_HI;
	wire logic und_a = fmt_a < aisd_pkg::LIM_A_LO;
	wire logic ovr_b = fmt_b > aisd_pkg::LIM_B_HI;
	wire logic und_b = fmt_b < aisd_pkg::LIM_B_LO;

	wire logic ovr = (is_a & ovr_a) | (is_b & ovr_b);
	wire logic und = (is_a & und_a) | (is_b & und_b);
	wire logic [15:0] lin = is_a ? fmt_a[15:0] : fmt_b[15:0];

	// deactivated or unknown code gives zero, so no stale value leaks out
	assign res_out.value    = (!(is_a | is_b)) ? 16'h0000 :
	                          ovr ? aisd_pkg::SAT_HI :
	                          und ? aisd_pkg::SAT_LO : lin;
	assign res_out.over     = ovr;
	assign res_out.under    = und;
	assign res_out.bad_code = !(is_a | is_b | is_off);
	assign res_out.off      = is_off;

endmodule : aisd_scale

// ==== aisd_coupler.sv ====
// Coupler model: issues record reads and writes on the record port.
// Assumes strobes are taken on MCLK_IN and answered one cycle later.
`timescale 1ns/1ps
module aisd_coupler (
	input  wire logic           MCLK_IN,
	output aisd_pkg::aisd_req_t req_out,
	input  wire logic [7:0]     rdata_in,
	input  wire logic           ack_in,
	input  wire logic           err_in
);
	// Idle request at time zero
	initial req_out = '0;

	// One record access, status returned as {ack, err}
	// record set access
	task automatic access(input logic w, input logic [7:0] num, input logic [4:0] idx,
		input logic [7:0] wd, output logic [7:0] rd, output logic [1:0] st);
		@(posedge MCLK_IN);
		#1;
		req_out = '{rd: !w, wr: w, num: num, idx: idx, wdata: wd};
		@(posedge MCLK_IN);
		#1;
		rd = rdata_in;
		st = {ack_in, err_in};
		// Strobe is one cycle; spoil the fields so stale values never look valid
		req_out = '{rd: 1'b0, wr: 1'b0, num: ~num, idx: ~idx, wdata: ~wd};
	endtask : access
endmodule : aisd_coupler

// ==== aisd_top_tb.sv ====
// Self-checking bench for the input block: scaling, record and timestamp.
// Assumes the coupler model alone drives the record port.
`timescale 1ns/1ps
module aisd_top_tb;
	logic                mclk;
	logic                resetn;
	logic [3:0][15:0]    ai_raw;
	logic                ai_valid;
	logic                mod_fail;
	logic                int_err;
	logic                aux_ok;
	aisd_pkg::aisd_req_t req;
	logic [7:0]          rdata;
	logic                ack;
	logic                err;
	logic [3:0][15:0]    ai_value;
	logic [3:0]          ch_led;
	logic                mod_led;
	int                  n_errors;
	int                  n_checks;
	int                  cyc;
	int                  rel;
	int                  stamp_cyc;

	aisd_top i_aisd_top (
		.MCLK_IN(mclk), .RESETN_IN(resetn), .AI_RAW_IN(ai_raw), .AI_VALID_IN(ai_valid),
		.MOD_FAIL_IN(mod_fail), .INT_ERR_IN(int_err), .AUX_OK_IN(aux_ok),
		.REC_REQ_IN(req), .REC_RDATA_OUT(rdata), .REC_ACK_OUT(ack), .REC_ERR_OUT(err),
		.AI_VALUE_OUT(ai_value), .CH_LED_OUT(ch_led), .MOD_LED_OUT(mod_led));

	aisd_coupler i_aisd_coupler (
		.MCLK_IN(mclk), .req_out(req), .rdata_in(rdata), .ack_in(ack), .err_in(err));

	// 200 MHz clock
	initial begin
		mclk = 1'b0;
		forever #2.5 mclk = ~mclk;
	end

	// Cycle count; also cuts a hang short
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			n_errors++;
			stop_test();
		end
	end

	task automatic stop_test();
		if (n_errors == 0 && n_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_byte

	task automatic chk_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_word

	// Accepted read with expected byte
	task automatic rd_exp(input logic [7:0] num, input logic [4:0] idx, input logic [7:0] exp);
		logic [7:0] d;
		logic [1:0] st;
		i_aisd_coupler.access(1'b0, num, idx, 8'h00, d, st);
		chk_byte("read status", 8'h02, {6'h00, st});
		chk_byte("read data", exp, d);
	endtask : rd_exp

	// Refused access: error with zero data
	task automatic rd_bad(input logic w, input logic [7:0] num, input logic [4:0] idx);
		logic [7:0] d;
		logic [1:0] st;
		i_aisd_coupler.access(w, num, idx, 8'h20, d, st);
		chk_byte("refused status", 8'h03, {6'h00, st});
		chk_byte("refused data", 8'h00, d);
	endtask : rd_bad

	task automatic wr_code(input logic [1:0] ch, input logic [7:0] code);
		logic [7:0] d;
		logic [1:0] st;
		i_aisd_coupler.access(1'b1, {6'h20, ch}, 5'h00, code, d, st);
		chk_byte("write status", 8'h02, {6'h00, st});
	endtask : wr_code

	// One converter sample for all channels; outputs land one cycle later
	task automatic sample(input logic [3:0][15:0] raw);
		@(posedge mclk);
		#1;
		ai_raw = raw;
		ai_valid = 1'b1;
		@(posedge mclk);
		#1;
		stamp_cyc = cyc - rel;
		ai_valid = 1'b0;
	endtask : sample

	// Channel value and its fault byte
	task automatic chk_ch(input int n, input logic [15:0] v, input logic [7:0] f);
		chk_word("scaled value", v, ai_value[n]);
		rd_exp(8'h01, 5'(8 + n), f);
	endtask : chk_ch

	// Group byte, summary byte and the LEDs that follow them
	task automatic diag(input logic [7:0] grp, input logic [7:0] sum);
		chk_byte("channel leds", grp, {4'h0, ch_led});
		chk_byte("module led", {7'h00, sum != 8'h00}, {7'h00, mod_led});
		rd_exp(8'h01, 5'h07, grp);
		rd_exp(8'h01, 5'h00, sum);
	endtask : diag

	// Fixed record bytes and reset defaults
	task automatic t_reset();
		logic [7:0] rec [20];
		rec = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00,
			8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 20; i++) begin
			rd_exp(8'h01, 5'(i), rec[i]);
		end
		for (int i = 0; i < 4; i++) begin
			rd_exp(8'h00, 5'(i), rec[i]);
			rd_exp({6'h20, 2'(i)}, 5'h00, 8'h10);
		end
		rd_bad(1'b0, 8'h00, 5'h04);
		rd_bad(1'b0, 8'h01, 5'h14);
		rd_bad(1'b0, 8'h02, 5'h00);
		rd_bad(1'b1, 8'h01, 5'h00);
	endtask : t_reset

	// First format at its limits, with the event timestamp
	task automatic t_fmt_a();
		logic [7:0] d;
		logic [1:0] st;
		logic [31:0] s;
		int e;
		repeat (450) @(posedge mclk);
		sample({16'hc000, 16'h4b43, 16'h4b42, 16'h4000});
		e = stamp_cyc / 200;
		for (int i = 0; i < 4; i++) begin
			i_aisd_coupler.access(1'b0, 8'h01, 5'(16 + i), 8'h00, d, st);
			s[8*i +: 8] = d;
		end
		chk_byte("stamp in range", 8'h01, {7'h00, s == e || s == e - 1});
		chk_ch(0, 16'h6c00, 8'h00);
		chk_ch(1, 16'h7eff, 8'h00);
		chk_ch(2, 16'h7fff, 8'h80);
		chk_ch(3, 16'h8000, 8'h40);
		diag(8'h0c, 8'h0c);
	endtask : t_fmt_a

	// Second format at its limits
	task automatic t_fmt_b();
		for (int i = 0; i < 4; i++) begin
			wr_code(2'(i), 8'h20);
		end
		sample({16'hf332, 16'h5001, 16'h5000, 16'hf333});
		chk_ch(0, 16'hf333, 8'h00);
		chk_ch(1, 16'h5000, 8'h00);
		chk_ch(2, 16'h7fff, 8'h80);
		chk_ch(3, 16'h8000, 8'h40);
		diag(8'h0c, 8'h0c);
	endtask : t_fmt_b

	// Deactivated channel and a bad range code
	task automatic t_off();
		wr_code(2'd0, 8'hff);
		wr_code(2'd1, 8'h33);
		sample({16'h0000, 16'h4000, 16'h4000, 16'h7fff});
		chk_ch(0, 16'h0000, 8'h00);
		chk_ch(1, 16'h0000, 8'h01);
		chk_ch(2, 16'h4000, 8'h00);
		diag(8'h02, 8'h88);
	endtask : t_off

	// Module level faults in the summary byte
	task automatic t_summary();
		wr_code(2'd0, 8'h10);
		wr_code(2'd1, 8'h10);
		mod_fail = 1'b1;
		int_err = 1'b1;
		aux_ok = 1'b0;
		sample('0);
		repeat (3) @(posedge mclk);
		diag(8'h00, 8'h13);
		mod_fail = 1'b0;
		int_err = 1'b0;
		aux_ok = 1'b1;
		repeat (4) @(posedge mclk);
		diag(8'h00, 8'h00);
	endtask : t_summary

	// Main sequence
	initial begin
		n_errors = 0;
		n_checks = 0;
		cyc = 0;
		resetn = 1'b0;
		ai_raw = '0;
		ai_valid = 1'b0;
		mod_fail = 1'b0;
		int_err = 1'b0;
		aux_ok = 1'b1;
		repeat (6) @(posedge mclk);
		#1;
		resetn = 1'b1;
		rel = cyc;
		t_reset();
		t_fmt_a();
		t_fmt_b();
		t_off();
		t_summary();
		stop_test();
	end
endmodule : aisd_top_tb
